// ---- shared/pss_pkg.sv ----
// pss_pkg: constants, states and carrier structs for the pin-driven power sequencer
// assumes a 100 MHz clock; all control pins are asynchronous to it
`default_nettype none
package pss_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_PS     = 10000;
  localparam int unsigned RESET_DELAY_MS    = 50;
  localparam int unsigned RESET_DELAY_CYC   = RESET_DELAY_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int unsigned RAMP_TIMEOUT_US   = 10;
  localparam int unsigned RAMP_TIMEOUT_CYC  = RAMP_TIMEOUT_US * (1000000 / CLK_PERIOD_PS);

  // rail indices in the primary group
  localparam int unsigned NUM_RAILS         = 8;
  localparam int unsigned RAIL_ALWAYS_LO    = 0;
  localparam int unsigned RAIL_ALWAYS_HI    = 2;
  localparam int unsigned RAIL_DOMB_LO      = 3;
  localparam int unsigned RAIL_DOMB_HI      = 5;
  localparam int unsigned RAIL_DOMC_LO      = 6;
  localparam int unsigned RAIL_DOMC_HI      = 7;

  // core buck level codes, 25 mV steps
  localparam logic [7:0]  CORE_NORMAL_RESET = 8'h20;
  localparam logic [7:0]  CORE_SLEEP_RESET  = 8'h1C;

  // register port
  localparam logic [3:0]  REG_CORE_NORMAL   = 4'h0;
  localparam logic [3:0]  REG_CORE_SLEEP    = 4'h1;
  localparam logic [3:0]  REG_MERGED_CH2    = 4'h2;
  localparam logic [3:0]  REG_STATUS        = 4'h3;
  localparam logic [3:0]  REG_RAIL_EN       = 4'h4;

  typedef enum logic [2:0]
  {
    SEQ_OFF    = 3'b000,
    SEQ_ALWAYS = 3'b001,
    SEQ_DOMB   = 3'b010,
    SEQ_DOMC   = 3'b011,
    SEQ_ON     = 3'b100
  } pss_seq_t;

  typedef struct packed
  {
    logic systemEnable;
    logic switchAEnable;
    logic domainBEnable;
    logic sequenceStart;
    logic domainCEnable;
    logic coreVoltageSelect;
  } pss_ctl_t;

  typedef struct packed
  {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pss_reg_req_t;

endpackage
`default_nettype wire

// ---- hw/pss_sync.sv ----
// pss_sync: two-flop synchroniser bank for asynchronous pins
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none
module pss_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed
  {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pss_sync_state_t;

  pss_sync_state_t state;
  pss_sync_state_t next_state;

  // only the second stage is visible outside
  always_comb
  begin
    next_state.meta   = pinIn;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign syncOut = state.stable;

endmodule
`default_nettype wire

// ---- hw/pss_sequencer.sv ----
// pss_sequencer: pin-driven power sequencing for one factory variant
// assumes rail power-good inputs are asynchronous; register port on clk
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer #(
  parameter int unsigned RESET_DELAY_CYCLES = pss_pkg::RESET_DELAY_CYC,
  parameter int unsigned RAMP_TIMEOUT       = pss_pkg::RAMP_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // control pins, asynchronous
  input  wire pss_pkg::pss_ctl_t             ctlPins,
  // power-good of each primary rail, asynchronous
  input  wire logic [pss_pkg::NUM_RAILS-1:0] railGood,
  // register port
  input  wire pss_pkg::pss_reg_req_t         regReq,
  output logic      [31:0]                   regRdata,
  // rail enables and core level
  output logic      [pss_pkg::NUM_RAILS-1:0] railEnable,
  output logic      [7:0]                    coreBuckLevel,
  output logic                               loadSwitchA,
  // open-drain processor reset, low when driven
  output logic                               processorResetOut,
  output logic                               processorResetOe,
  // low-power load switch controls
  output logic                               loadSwitchCtrlOutA,
  output logic                               loadSwitchCtrlOutB,
  // sequence fault: a stage ramp did not reach power-good in time
  output logic                               rampFault
);

  localparam int unsigned NR = pss_pkg::NUM_RAILS;
  localparam int unsigned DW = $clog2(RESET_DELAY_CYCLES + 1);
  localparam int unsigned TW = $clog2(RAMP_TIMEOUT + 1);

  typedef struct packed
  {
    pss_pkg::pss_seq_t seq;
    logic [NR-1:0]     railEnable;
    logic [DW-1:0]     delayCount;
    logic              resetRelease;
    logic              resetDrive;
    logic [TW-1:0]     rampCount;
    logic              rampFault;
    logic [7:0]        coreNormal;
    logic [7:0]        coreSleep;
    logic [7:0]        coreBuckLevel;
    logic              loadSwitchA;
    logic              ctrlOutA;
    logic              ctrlOutB;
    logic [31:0]       rdata;
  } pss_state_t;

  pss_state_t        state;
  pss_state_t        next_state;
  pss_pkg::pss_ctl_t ctl;
  logic [NR-1:0]     good;

  // pins cross into clk before anything reads them
  pss_sync #(
    .WIDTH ($bits(pss_pkg::pss_ctl_t) + NR)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   ({ctlPins, railGood}),
    .syncOut ({ctl, good})
  );

  // rail group masks
  logic [NR-1:0] maskAlways;
  logic [NR-1:0] maskDomB;
  logic [NR-1:0] maskDomC;

  for (genvar i = 0; i < NR; i++)
  begin : g_mask
    assign maskAlways[i] = (i >= pss_pkg::RAIL_ALWAYS_LO) && (i <= pss_pkg::RAIL_ALWAYS_HI);
    assign maskDomB[i]   = (i >= pss_pkg::RAIL_DOMB_LO) && (i <= pss_pkg::RAIL_DOMB_HI);
    assign maskDomC[i]   = (i >= pss_pkg::RAIL_DOMC_LO) && (i <= pss_pkg::RAIL_DOMC_HI);
  end

  logic alwaysGood;
  logic domBGood;
  logic domCGood;
  logic stageGood;

  always_comb
  begin
    alwaysGood = &(good | ~maskAlways);
    domBGood   = &(good | ~maskDomB);
    domCGood   = &(good | ~maskDomC);
    stageGood  = 1'b0;
    unique case (state.seq)
      pss_pkg::SEQ_ALWAYS: stageGood = alwaysGood;
      pss_pkg::SEQ_DOMB:   stageGood = domBGood;
      pss_pkg::SEQ_DOMC:   stageGood = domCGood;
      default:             stageGood = 1'b1;
    endcase
  end

  always_comb
  begin
    next_state = state;

    // primary sequence; each stage waits for the previous group's power-good unless that group's enable pin is low
    unique case (state.seq)
      pss_pkg::SEQ_OFF:
      begin
        if (ctl.sequenceStart && ctl.systemEnable)
          next_state.seq = pss_pkg::SEQ_ALWAYS;
      end
      pss_pkg::SEQ_ALWAYS:
      begin
        if (alwaysGood)
          next_state.seq = pss_pkg::SEQ_DOMB;
      end
      pss_pkg::SEQ_DOMB:
      begin
        if (domBGood || !ctl.domainBEnable)
          next_state.seq = pss_pkg::SEQ_DOMC;
      end
      pss_pkg::SEQ_DOMC:
      begin
        if (domCGood || !ctl.domainCEnable)
          next_state.seq = pss_pkg::SEQ_ON;
      end
      pss_pkg::SEQ_ON:
      begin
      end
      default:
        next_state.seq = pss_pkg::SEQ_OFF;
    endcase
    if (!ctl.sequenceStart || !ctl.systemEnable)
      next_state.seq = pss_pkg::SEQ_OFF;

    // enables per group, gated by pins and prerequisites
    next_state.railEnable = '0;
    if (next_state.seq != pss_pkg::SEQ_OFF)
      next_state.railEnable = maskAlways;
    if ((next_state.seq == pss_pkg::SEQ_DOMB || next_state.seq == pss_pkg::SEQ_DOMC
         || next_state.seq == pss_pkg::SEQ_ON) && alwaysGood && ctl.domainBEnable)
      next_state.railEnable = next_state.railEnable | maskDomB;
    if ((next_state.seq == pss_pkg::SEQ_DOMC || next_state.seq == pss_pkg::SEQ_ON)
        && alwaysGood && ctl.domainCEnable)
      next_state.railEnable = next_state.railEnable | maskDomC;

    // stage ramp watchdog; flag clears only when the sequence falls back to off
    if (state.seq != next_state.seq || stageGood)
      next_state.rampCount = '0;
    else if (state.rampCount != TW'(RAMP_TIMEOUT))
      next_state.rampCount = state.rampCount + TW'(1);
    if (state.rampCount == TW'(RAMP_TIMEOUT) && !stageGood)
      next_state.rampFault = 1'b1;
    else if (next_state.seq == pss_pkg::SEQ_OFF)
      next_state.rampFault = 1'b0;

    // processor reset: held low while system enable low, then counted delay
    if (!ctl.systemEnable)
    begin
      next_state.delayCount   = '0;
      next_state.resetRelease = 1'b0;
    end
    else if (!state.resetRelease)
    begin
      if (state.delayCount == DW'(RESET_DELAY_CYCLES - 1))
        next_state.resetRelease = 1'b1;
      else
        next_state.delayCount = state.delayCount + DW'(1);
    end
    // registered copy so the pin driver comes straight from a flop
    next_state.resetDrive = !next_state.resetRelease;

    // core buck target from the select pin
    next_state.coreBuckLevel = ctl.coreVoltageSelect ? state.coreSleep : state.coreNormal;

    // independent load switch
    next_state.loadSwitchA = ctl.switchAEnable;

    // low-power load switch controls follow their domain's rails being good
    next_state.ctrlOutA = (state.seq == pss_pkg::SEQ_ON) && ctl.domainBEnable && domBGood;
    next_state.ctrlOutB = (state.seq == pss_pkg::SEQ_ON) && ctl.domainCEnable && domCGood;

    // register writes replace the factory defaults
    if (regReq.wr)
    begin
      unique case (regReq.addr)
        pss_pkg::REG_CORE_NORMAL: next_state.coreNormal = regReq.wdata[7:0];
        pss_pkg::REG_CORE_SLEEP:  next_state.coreSleep  = regReq.wdata[7:0];
        default:
        begin
        end
      endcase
    end

    // reads answer in the next cycle; unmapped and merged channel read zero
    next_state.rdata = '0;
    if (regReq.rd)
    begin
      unique case (regReq.addr)
        pss_pkg::REG_CORE_NORMAL: next_state.rdata = {24'h000000, state.coreNormal};
        pss_pkg::REG_CORE_SLEEP:  next_state.rdata = {24'h000000, state.coreSleep};
        pss_pkg::REG_MERGED_CH2:  next_state.rdata = 32'h00000000;
        pss_pkg::REG_STATUS:      next_state.rdata = {24'h000000, state.rampFault, state.resetRelease,
                                                     state.loadSwitchA, 2'h0, state.seq};
        pss_pkg::REG_RAIL_EN:     next_state.rdata = {{(32-NR){1'b0}}, state.railEnable};
        default:                  next_state.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state            <= '0;
      state.seq        <= pss_pkg::SEQ_OFF;
      state.coreNormal <= pss_pkg::CORE_NORMAL_RESET;
      state.coreSleep  <= pss_pkg::CORE_SLEEP_RESET;
      state.coreBuckLevel <= pss_pkg::CORE_NORMAL_RESET;
      state.resetDrive    <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign regRdata           = state.rdata;
  assign railEnable         = state.railEnable;
  assign coreBuckLevel      = state.coreBuckLevel;
  assign loadSwitchA        = state.loadSwitchA;
  // open drain: pull low until released; an external button may still ground it
  assign processorResetOut  = 1'b0;
  assign processorResetOe   = state.resetDrive;
  assign loadSwitchCtrlOutA = state.ctrlOutA;
  assign loadSwitchCtrlOutB = state.ctrlOutB;
  assign rampFault          = state.rampFault;

endmodule
`default_nettype wire

// ---- bench/pss_sequencer_props.sv ----
// pss_sequencer_props: port checks for the power sequencer
// bound onto pss_sequencer; pins come from a host clocked on clk
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_props #(
  parameter int unsigned RESET_DELAY_CYCLES = 20
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // watched ports
  input wire pss_pkg::pss_ctl_t     ctlPins,
  input wire logic [7:0]            railGood,
  input wire pss_pkg::pss_reg_req_t regReq,
  input wire logic [31:0]           regRdata,
  input wire logic [7:0]            railEnable,
  input wire logic [7:0]            coreBuckLevel,
  input wire logic                  loadSwitchA,
  input wire logic                  processorResetOe
);
  // saturates so a long high run cannot wrap
  int unsigned hiCnt;
  logic [7:0]  normLvl;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hiCnt   <= 0;
      normLvl <= pss_pkg::CORE_NORMAL_RESET;
    end
    else
    begin
      hiCnt <= !ctlPins.systemEnable ? 0 : (hiCnt < 999 ? hiCnt + 1 : hiCnt);
      if (regReq.wr && regReq.addr == pss_pkg::REG_CORE_NORMAL)
        normLvl <= regReq.wdata[7:0];
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_held_low: assert property ((!ctlPins.systemEnable) [*3] |=> processorResetOe)
    else $error("reset not held while enable low");
  a_reset_not_early: assert property ($fell(processorResetOe) |-> hiCnt >= RESET_DELAY_CYCLES)
    else $error("reset released early");
  a_switch_follows: assert property (ctlPins.switchAEnable [*3] |=> loadSwitchA)
    else $error("switch a not on");
  a_core_normal: assert property ((!ctlPins.coreVoltageSelect) [*4] |=> coreBuckLevel == $past(normLvl))
    else $error("core level wrong");
  a_merged_zero: assert property (regReq.rd && regReq.addr == pss_pkg::REG_MERGED_CH2 |=> regRdata == 32'h0)
    else $error("merged channel read not zero");
  a_domb_cleared: assert property ((!ctlPins.domainBEnable) [*4] |=> railEnable[5:3] == 3'h0)
    else $error("domain b rails on");
  a_seq_gated: assert property ((!(ctlPins.sequenceStart && ctlPins.systemEnable)) [*4] |=> railEnable == 8'h00)
    else $error("rails on without start");
  a_domb_prereq: assert property ($rose(railEnable[3]) |-> $past(&railGood[2:0], 3))
    else $error("domain b before prior goods");

  cover property ($fell(processorResetOe));
  cover property (railEnable == 8'hFF);
  cover property ($rose(loadSwitchA));
endmodule

bind pss_sequencer pss_sequencer_props #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) i_pss_sequencer_props (
  .clk, .rst_n, .ctlPins, .railGood, .regReq, .regRdata, .railEnable, .coreBuckLevel, .loadSwitchA,
  .processorResetOe);
`default_nettype wire

// ---- bench/pss_host_model.sv ----
// pss_host_model: system controller pins and rail ramps facing the sequencer
// assumes the sequencer's clock; reset line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module pss_host_model #(
  parameter int unsigned GOOD_DELAY = 3
) (
  // clock and test controls
  input  wire logic              clk,
  input  wire pss_pkg::pss_ctl_t cmd,
  input  wire logic              stall,
  // sequencer side
  input  wire logic [7:0]        railEnable,
  input  wire logic              processorResetOe,
  output wire pss_pkg::pss_ctl_t ctlPins,
  output wire logic [7:0]        railGood,
  output wire logic              resetLine
);
  pss_pkg::pss_ctl_t          held = '0;
  logic [GOOD_DELAY-1:0][7:0] ramp = '0;
  always @(posedge clk)
  begin
    held <= cmd;
    ramp <= {ramp[GOOD_DELAY-2:0], railEnable};
  end
  assign ctlPins = held;
  // stall keeps switched domains from reaching good
  // low-power states left out, so no load switch sits behind the ctrl outputs
  assign railGood = ramp[GOOD_DELAY-1] & (stall ? 8'h07 : 8'hFF);
  // pull-up unless the sequencer grounds it
  assign resetLine = !processorResetOe;
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// tb: directed tests of the pin-driven power sequencer
// assumes the bound checker and a short reset delay parameter
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned DLY = 20;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  stall = 1'b0;
  pss_pkg::pss_ctl_t     cmd = '0;
  pss_pkg::pss_reg_req_t regReq = '0;
  pss_pkg::pss_ctl_t     ctlPins;
  logic [7:0]            railGood, railEnable, coreLvl;
  logic [31:0]           regRdata;
  logic                  swA, resetOe, resetOut, resetLine, ctrlA, ctrlB, rampFault;
  int                    err_total = 0;
  int                    num_checks = 0;

  always #5 clk = ~clk;

  pss_sequencer #(.RESET_DELAY_CYCLES(DLY), .RAMP_TIMEOUT(16)) i_pss_sequencer (
    .clk, .rst_n, .ctlPins, .railGood, .regReq, .regRdata, .railEnable, .coreBuckLevel(coreLvl),
    .loadSwitchA(swA), .processorResetOut(resetOut), .processorResetOe(resetOe), .loadSwitchCtrlOutA(ctrlA),
    .loadSwitchCtrlOutB(ctrlB), .rampFault);
  pss_host_model i_pss_host_model (
    .clk, .cmd, .stall, .railEnable, .processorResetOe(resetOe), .ctlPins, .railGood, .resetLine);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // strobe drops after one edge; the short pause keeps the next call off this time step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    regReq <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    regReq <= '0;
    #1 chk(regRdata, exp);
  endtask
  task automatic waitFor(input logic [7:0] exp);
    for (int i = 0; i < 200 && railEnable !== exp; i++)
      @(posedge clk);
    chk(32'(railEnable), 32'(exp));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(1);
    chk(32'(coreLvl), 32'h20);
    chk(32'(resetOe), 1);
    rd(pss_pkg::REG_CORE_SLEEP, 32'h1C);
    wr(pss_pkg::REG_MERGED_CH2, 32'hFF);
    rd(pss_pkg::REG_MERGED_CH2, 0);
    rd(4'hF, 0);
    wr(pss_pkg::REG_CORE_NORMAL, 32'h30);
    wr(pss_pkg::REG_CORE_SLEEP, 32'h2C);
    rd(pss_pkg::REG_CORE_NORMAL, 32'h30);
    cyc(2);
    chk(32'(coreLvl), 32'h30);
    cmd <= 6'b010001;
    cyc(6);
    chk(32'(coreLvl), 32'h2C);
    chk(32'(swA), 1);
    cmd <= '0;
    cyc(6);
    chk(32'(swA), 0);
    $display("test registers and pins done");
    cmd.systemEnable <= 1'b1;
    cyc(16);
    chk(32'(resetOe), 1);
    cyc(14);
    chk(32'(resetOe), 0);
    chk(32'(resetLine), 1);
    chk(32'(resetOut), 0);
    cmd.systemEnable <= 1'b0;
    cyc(5);
    chk(32'(resetOe), 1);
    cmd.systemEnable <= 1'b1;
    cyc(10);
    cmd.systemEnable <= 1'b0;
    cyc(2);
    cmd.systemEnable <= 1'b1;
    cyc(16);
    chk(32'(resetOe), 1);
    $display("test reset delay done");
    cmd <= 6'b101110;
    waitFor(8'hFF);
    cyc(8);
    chk(32'({ctrlA, ctrlB}), 3);
    cmd.domainBEnable <= 1'b0;
    cyc(6);
    chk(32'({ctrlA, railEnable}), 32'hC7);
    cmd.domainCEnable <= 1'b0;
    cyc(6);
    chk(32'(railEnable), 32'h07);
    cmd.sequenceStart <= 1'b0;
    waitFor(8'h00);
    $display("test sequence done");
    stall <= 1'b1;
    cmd <= 6'b101110;
    waitFor(8'h3F);
    cyc(30);
    chk(32'(rampFault), 1);
    rd(pss_pkg::REG_STATUS, 32'hC2);
    rd(pss_pkg::REG_RAIL_EN, 32'h3F);
    stall <= 1'b0;
    cmd <= 6'b100000;
    waitFor(8'h00);
    cyc(2);
    chk(32'(rampFault), 0);
    $display("test stalled ramp done");
    test_done;
  end

  // about ten times the expected run
  initial
  begin
    #20000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end
endmodule
`default_nettype wire
